// *** verilog/digital_control_port.sv ***
// Purpose: seven-pin configurable digital control port with APB registers
// Assumes: pins synchronous-sampled, shutdown mode kept by software in nv store
// Notes: all outputs registered; pin output enable is active low
`timescale 1ns/1ps
// Summary of operation
// (R1) any pin can be input-only with polarity, read in input word
// (R2) input word shows external pin level, not output word
// (R3) pins 7..1 map to data bits 6..0
// (R4) trigger input fires on rising edge (positive) or falling (negative)
// (R5) internal trigger delivered within five microseconds of edge
// (R6) source holds pulses at least 4 us positive, 10 us negative
// (R7) trigger output emits one 10 us pulse at chosen polarity
// (R8) fault pair asserts fault pin on any channel protection fault
// (R9) fault stays asserted until cause gone and protection cleared
// (R10) while pin 1 is fault, pin 2 function ignored; code only floats pin 2, a pin 2 trigger input still fires triggerIn
// (R11) pin 3 shutdown input is level sensed, acted on within 5 us
// (R12) shutdown gates all output channels together
// (R13) latching mode: true transition disables until mode rewritten
// (R14) live mode: outputs follow shutdown input
// (R15) off mode ignores input; mode kept across power cycles; code resets mode and shdnModeNv to off
// (R16) chained units use same polarity for fault and shutdown
// (R17) switch to common needs negative polarity on all pins
// (R18) live chain cleared by clearing protection on one unit
// (R19) latching chain re-armed by off then latching on each unit
// (R20) output sync function accepted only on pins 4 to 7
// (R21) inputs synchronised and polarity applied before detection
module digital_control_port #(
  parameter int unsigned CHANNELS = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dport_pkg::PIN_COUNT-1:0] pinIn,
  output logic [dport_pkg::PIN_COUNT-1:0] pinOut,
  output logic [dport_pkg::PIN_COUNT-1:0] pinOe_n,
  input wire logic [CHANNELS-1:0] chanFault,
  input wire logic [CHANNELS-1:0] outputReq,
  input wire logic triggerOutReq,
  input wire logic syncIn,
  output logic [CHANNELS-1:0] outputEnable,
  output logic triggerIn,
  output logic syncOut,
  output logic [1:0] shdnModeNv
);
  import dport_pkg::*;

  pin_func_t func [PIN_COUNT];
  logic [PIN_COUNT-1:0] pol;
  logic [PIN_COUNT-1:0] dataOut;
  shdn_mode_t shdnMode;
  logic [PIN_COUNT-1:0] level;
  logic [PIN_COUNT-1:0] levelPrev;
  logic [PIN_COUNT-1:0] pulseActive;
  logic faultLatched;
  logic shdnLatched;
  logic shdnPrev;
  logic clearReq;
  logic setupWr;
  logic [31:0] next_prdata;
  logic faultMode;
  logic shdnActive;
  logic [PIN_COUNT-1:0] trigEdge;

  // apb answers in the access cycle, no wait states
  assign setupWr = psel && penable && pwrite && pready;
  assign faultMode = (func[0] == fault_output_function);
  // (R11) level sensed shutdown
  assign shdnActive = (func[2] == shutdown_input_function) && level[2];

  // (R21) sync then polarity
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      pin_sync u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pinIn(pinIn[g]),
        .negPol(pol[g]),
        .level(level[g])
      );
      pulse_gen #(.W(PULSE_W), .WIDTH(PULSE_W'(PULSE_CYCLES))) u_pulse (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .fire(triggerOutReq && func[g] == trigger_output_function),
        .active(pulseActive[g])
      );
      // (R4) polarity-corrected rising edge
      assign trigEdge[g] = (func[g] == trigger_input_function) && level[g] && !levelPrev[g];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // configuration writes
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        func[i] <= pin_func_t'(FUNC_RESET);
      end
      pol <= POL_RESET;
      dataOut <= '0;
      shdnMode <= shdn_mode_t'(SHDN_RESET);
    end else if (setupWr) begin
      if (paddr == FUNC_LO_OFS || paddr == FUNC_HI_OFS) begin
        for (int i = 0; i < 4; i++) begin
          automatic int p = (paddr == FUNC_HI_OFS) ? i + 4 : i;
          automatic logic [2:0] f = pwdata[4*i +: 3];
          // (R20) sync only pins 4..7
          if (p < PIN_COUNT && f <= 3'(output_sync_function) && !(f == 3'(output_sync_function) && p < 3)
              && !(f == 3'(fault_output_function) && p != 0) && !(f == 3'(shutdown_input_function) && p != 2)) begin
            func[p] <= pin_func_t'(f);
          end
        end
      end else if (paddr == POL_OFS) begin
        pol <= pwdata[PIN_COUNT-1:0];
      end else if (paddr == DOUT_OFS) begin
        dataOut <= pwdata[PIN_COUNT-1:0];
      end else if (paddr == SHDN_OFS) begin
        if (pwdata[1:0] <= 2'(SHDN_LIVE)) begin
          shdnMode <= shdn_mode_t'(pwdata[1:0]);
        end
      end
    end
  end

  // unmapped address only; rejected values give no error
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !(paddr == FUNC_LO_OFS || paddr == FUNC_HI_OFS || paddr == POL_OFS
                 || paddr == DOUT_OFS || paddr == DIN_OFS || paddr == SHDN_OFS || paddr == STAT_OFS
                 || paddr == CMD_OFS);
    end
  end

  // (R18) one clear releases fault
  assign clearReq = setupWr && paddr == CMD_OFS && pwdata[0];

  always_comb begin
    next_prdata = 32'h0;
    if (paddr == FUNC_LO_OFS) begin
      for (int i = 0; i < 4; i++) begin
        next_prdata[4*i +: 3] = func[i];
      end
    end else if (paddr == FUNC_HI_OFS) begin
      for (int i = 0; i < 3; i++) begin
        next_prdata[4*i +: 3] = func[i+4];
      end
    end else if (paddr == POL_OFS) begin
      next_prdata[PIN_COUNT-1:0] = pol;
    end else if (paddr == DOUT_OFS) begin
      next_prdata[PIN_COUNT-1:0] = dataOut;
    end else if (paddr == DIN_OFS) begin
      // (R1) (R2) (R3) live pin levels, pin n at bit n-1
      next_prdata[PIN_COUNT-1:0] = level;
    end else if (paddr == SHDN_OFS) begin
      next_prdata[1:0] = shdnMode;
    end else if (paddr == STAT_OFS) begin
      next_prdata[0] = faultLatched;
      next_prdata[1] = shdnLatched;
      next_prdata[2] = shdnActive;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      levelPrev <= '0;
      shdnPrev <= 1'b0;
      triggerIn <= 1'b0;
    end else begin
      levelPrev <= level;
      shdnPrev <= shdnActive;
      // (R5) trigger a few cycles after the edge
      triggerIn <= |trigEdge;
    end
  end

  // (R9) set wins over clear while cause remains
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      faultLatched <= 1'b0;
    end else if (|chanFault) begin
      faultLatched <= 1'b1;
    end else if (clearReq) begin
      faultLatched <= 1'b0;
    end
  end

  // (R13) latch on true transition; rewriting mode re-arms
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      shdnLatched <= 1'b0;
    end else if (shdnMode == SHDN_LATCHING && shdnActive && !shdnPrev) begin
      shdnLatched <= 1'b1;
    end else if (shdnMode != SHDN_LATCHING || (setupWr && paddr == SHDN_OFS)) begin
      shdnLatched <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      outputEnable <= '0;
      shdnModeNv <= 2'h0;
      syncOut <= 1'b0;
    end else begin
      shdnModeNv <= shdnMode;
      syncOut <= |outputReq;
      // (R12) (R14) (R15) one gate for all channels
      if (shdnLatched || (shdnMode == SHDN_LIVE && shdnActive)) begin
        outputEnable <= '0;
      end else begin
        outputEnable <= outputReq;
      end
    end
  end

  // pin drivers; inputs float (oe_n high)
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pinOut <= '0;
      pinOe_n <= '1;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        pinOut[i] <= 1'b0;
        pinOe_n[i] <= 1'b1;
        case (func[i])
          bidirectional_io_function: begin
            pinOut[i] <= dataOut[i] ^ pol[i];
            pinOe_n[i] <= 1'b0;
          end
          // (R7) pulse with polarity
          trigger_output_function: begin
            pinOut[i] <= pulseActive[i] ^ pol[i];
            pinOe_n[i] <= 1'b0;
          end
          // (R8) fault drive
          fault_output_function: begin
            pinOut[i] <= faultLatched ^ pol[i];
            pinOe_n[i] <= 1'b0;
          end
          output_sync_function: begin
            pinOut[i] <= (|outputReq) ^ pol[i];
            pinOe_n[i] <= 1'b0;
          end
          default: begin
          end
        endcase
      end
      // (R10) pin 2 is fault return
      if (faultMode) begin
        pinOut[1] <= 1'b0;
        pinOe_n[1] <= 1'b1;
      end
    end
  end

  property p_fault_hold;
    @(posedge ref_clk) disable iff (!nrst) (faultLatched && !clearReq) |=> faultLatched;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without clear"); // (R9)
  property p_fault_set;
    @(posedge ref_clk) disable iff (!nrst) (|chanFault) |=> faultLatched;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched"); // (R8)
  property p_live;
    @(posedge ref_clk) disable iff (!nrst) (shdnMode == SHDN_LIVE && shdnActive) |=> outputEnable == '0;
  endproperty
  a_live: assert property (p_live) else $error("live shutdown ignored"); // (R14)
  property p_latch;
    @(posedge ref_clk) disable iff (!nrst) (shdnLatched && shdnMode == SHDN_LATCHING) |=> outputEnable == '0;
  endproperty
  a_latch: assert property (p_latch) else $error("latched shutdown ignored"); // (R13)
  property p_off;
    @(posedge ref_clk) disable iff (!nrst) (shdnMode == SHDN_OFF && $stable(shdnMode)) |=> outputEnable == $past(outputReq);
  endproperty
  a_off: assert property (p_off) else $error("off mode gated outputs"); // (R15)
  property p_trig;
    @(posedge ref_clk) disable iff (!nrst) (|trigEdge) |=> triggerIn;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger late"); // (R5)
  property p_sync_pin;
    @(posedge ref_clk) disable iff (!nrst) func[0] != output_sync_function && func[1] != output_sync_function
      && func[2] != output_sync_function;
  endproperty
  a_sync_pin: assert property (p_sync_pin) else $error("sync on low pin"); // (R20)
  property p_pin2;
    @(posedge ref_clk) disable iff (!nrst) faultMode |=> pinOe_n[1];
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin 2 driven in fault mode"); // (R10)
  c_fault: cover property (@(posedge ref_clk) disable iff (!nrst) faultLatched ##1 !faultLatched);
  c_trig: cover property (@(posedge ref_clk) disable iff (!nrst) triggerIn);
  c_latch: cover property (@(posedge ref_clk) disable iff (!nrst) shdnLatched);
endmodule : digital_control_port

// *** pkg/dport_pkg.sv ***
// Purpose: shared constants and types for the seven-pin digital control port
// Assumes: 200 MHz ref_clk, APB slave with 32-bit data
// Notes: register offsets are byte addresses
package dport_pkg;
  localparam int unsigned PIN_COUNT = 7;
  localparam int unsigned CLK_MHZ = 200;
  // times in nanoseconds
  localparam int unsigned TRIG_LATENCY_NS = 5000;
  localparam int unsigned TRIG_PULSE_NS = 10000;
  localparam int unsigned PULSE_CYCLES = (TRIG_PULSE_NS * CLK_MHZ) / 1000;
  localparam int unsigned LATENCY_CYCLES = (TRIG_LATENCY_NS * CLK_MHZ) / 1000;

  // register offsets
  localparam logic [7:0] FUNC_LO_OFS = 8'h00;
  localparam logic [7:0] FUNC_HI_OFS = 8'h04;
  localparam logic [7:0] POL_OFS = 8'h08;
  localparam logic [7:0] DOUT_OFS = 8'h0c;
  localparam logic [7:0] DIN_OFS = 8'h10;
  localparam logic [7:0] SHDN_OFS = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h18;
  localparam logic [7:0] CMD_OFS = 8'h1c;

  localparam logic [2:0] FUNC_RESET = 3'h0;
  localparam logic [6:0] POL_RESET = 7'h00;
  localparam logic [1:0] SHDN_RESET = 2'h0;
  localparam int unsigned PULSE_W = 12;

  typedef enum logic [2:0] {
    bidirectional_io_function,
    input_only_function,
    trigger_input_function,
    trigger_output_function,
    fault_output_function,
    shutdown_input_function,
    output_sync_function
  } pin_func_t;

  typedef enum logic [1:0] {
    SHDN_OFF,
    SHDN_LATCHING,
    SHDN_LIVE
  } shdn_mode_t;
endpackage : dport_pkg

// *** verilog/pin_sync.sv ***
// Purpose: two-stage synchroniser with polarity applied after the second stage
// Assumes: one clock
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module pin_sync (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pinIn,
  input wire logic negPol,
  output logic level
);
  logic meta;
  logic stable;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta <= 1'b0;
      stable <= 1'b0;
      level <= 1'b0;
    end else begin
      meta <= pinIn;
      stable <= meta;
      level <= stable ^ negPol;
    end
  end
endmodule : pin_sync

// *** verilog/pulse_gen.sv ***
// Purpose: fixed-width output pulse on a one-cycle request
// Assumes: width below 2**W
// Notes: a new request while busy restarts nothing
`timescale 1ns/1ps
module pulse_gen #(
  parameter int unsigned W = 12,
  parameter logic [W-1:0] WIDTH = 12'd2000
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic fire,
  output logic active
);
  logic [W-1:0] count;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count <= '0;
      active <= 1'b0;
    end else if (fire && !active) begin
      count <= WIDTH - 1'b1;
      active <= 1'b1;
    end else if (active) begin
      if (count == '0) begin
        active <= 1'b0;
      end else begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : pulse_gen

// *** verif/ext_circuit.sv ***
// Purpose: outside circuit on the seven port pins
// Assumes: pull-up on every pin, outside drivers open unless enabled
// Notes: the port's own drive wins where its enable is low
`timescale 1ns/1ps
module ext_circuit (
  input wire logic [6:0] extLevel,
  input wire logic [6:0] extEn,
  input wire logic [6:0] pinOut,
  input wire logic [6:0] pinOe_n,
  output logic [6:0] pinIn
);
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (!pinOe_n[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extLevel[i];
      else pinIn[i] = 1'b1;
    end
  end
endmodule : ext_circuit

// *** verif/digital_control_port_tb.sv ***
// Purpose: self-checking bench for the digital control port
// Assumes: APB slave answers whenever pready rises, pins pulled up outside
// Notes: waits sample at the falling edge, APB results at the rising edge, inputs move on the rising edge
`timescale 1ns/1ps
module digital_control_port_tb;
  import dport_pkg::*;
  logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, triggerOutReq = 0, triggerIn, syncOut;
  logic [6:0] pinIn, pinOut, pinOe_n, extLevel = 7'h00, extEn = 7'h00;
  logic [3:0] chanFault = 4'h0, outputReq = 4'hb, outputEnable;
  logic [1:0] shdnModeNv;
  int failures = 0, checks_done = 0, trigCount = 0, trigBase = 0, n;
  shdn_mode_t modes[3] = '{SHDN_LIVE, SHDN_LATCHING, SHDN_OFF};

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (triggerIn === 1'b1) trigCount <= trigCount + 1;

  digital_control_port i_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe_n(pinOe_n), .chanFault(chanFault), .outputReq(outputReq),
    .triggerOutReq(triggerOutReq), .syncIn(1'b0), .outputEnable(outputEnable), .triggerIn(triggerIn),
    .syncOut(syncOut), .shdnModeNv(shdnModeNv));
  ext_circuit i_ext (.extLevel(extLevel), .extEn(extEn), .pinOut(pinOut), .pinOe_n(pinOe_n), .pinIn(pinIn));

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // pready, prdata and pslverr are taken at the rising edge that ends the access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      failures++;
      $display("MISMATCH apb pready expected 1 seen timeout");
      conclude();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdchk

  function automatic logic probe(input int sel);
    case (sel)
      0: return triggerIn;
      1: return pinOut[0];
      default: return |outputEnable;
    endcase
  endfunction : probe

  task automatic await(input int sel, input logic val, input int lim);
    for (n = 1; n <= lim; n++) begin
      @(negedge ref_clk);
      if (probe(sel) === val) return;
    end
    failures++;
    $display("MISMATCH wait %0d expected %b seen timeout", sel, val);
    conclude();
  endtask : await

  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    rdchk("funcLo", FUNC_LO_OFS, 32'h0);
    rdchk("pol", POL_OFS, 32'(POL_RESET));
    rdchk("shdn", SHDN_OFS, 32'(SHDN_RESET));
    // pins come out of reset as bidirectional, so they drive
    check("oeReset", 32'(pinOe_n), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("slverr", 32'(err), 32'h1);
    $display("test reset done");
    wr(FUNC_LO_OFS, 32'h1111);
    wr(FUNC_HI_OFS, 32'h111);
    wr(POL_OFS, 32'h0f);
    wr(DOUT_OFS, 32'h7f);
    extEn <= 7'h7f;
    extLevel <= 7'h55;
    repeat (8) @(posedge ref_clk);
    rdchk("din", DIN_OFS, 32'h5a);
    check("oeIn", 32'(pinOe_n), 32'h7f);
    $display("test input done");
    wr(FUNC_LO_OFS, 32'h1121);
    for (int p = 0; p < 2; p++) begin
      wr(POL_OFS, 32'(p * 2));
      extLevel[1] <= p[0];
      repeat (20) @(posedge ref_clk);
      trigBase = trigCount;
      extLevel[1] <= !p[0];
      await(0, 1'b1, LATENCY_CYCLES);
      repeat (p ? 2000 : 800) @(posedge ref_clk);
      extLevel[1] <= p[0];
      repeat (20) @(posedge ref_clk);
      check("trigCount", 32'(trigCount - trigBase), 32'h1);
    end
    $display("test trigger in done");
    wr(FUNC_LO_OFS, 32'h1113);
    for (int p = 0; p < 2; p++) begin
      wr(POL_OFS, 32'(p));
      repeat (4) @(posedge ref_clk);
      triggerOutReq <= 1'b1;
      @(posedge ref_clk);
      triggerOutReq <= 1'b0;
      await(1, !p[0], 5);
      check("oeTrig", 32'(pinOe_n[0]), 32'h0);
      await(1, p[0], 3000);
      check("pulseLen", 32'(n), 32'(PULSE_CYCLES));
    end
    $display("test trigger out done");
    wr(FUNC_LO_OFS, 32'h1134);
    wr(POL_OFS, 32'h0);
    @(posedge ref_clk);
    chanFault <= 4'h8;
    await(1, 1'b1, 20);
    wr(CMD_OFS, 32'h1);
    @(negedge ref_clk);
    check("faultSetWins", 32'(pinOut[0]), 32'h1);
    @(posedge ref_clk);
    chanFault <= 4'h0;
    repeat (20) @(negedge ref_clk);
    check("faultHeld", 32'(pinOut[0]), 32'h1);
    apb(1'b0, STAT_OFS, 32'h0);
    check("statFault", rd & 32'h1, 32'h1);
    triggerOutReq <= 1'b1;
    @(posedge ref_clk);
    triggerOutReq <= 1'b0;
    repeat (10) @(negedge ref_clk);
    check("pin2", 32'(pinOut[1]), 32'h0);
    check("pin2Oe", 32'(pinOe_n[1]), 32'h1);
    wr(CMD_OFS, 32'h1);
    await(1, 1'b0, 20);
    $display("test fault done");
    wr(FUNC_LO_OFS, 32'h1511);
    // negative polarity for a switch to common
    wr(POL_OFS, 32'h4);
    extLevel[2] <= 1'b1;
    foreach (modes[i]) begin
      wr(SHDN_OFS, 32'(modes[i]));
      repeat (10) @(negedge ref_clk);
      check("nv", 32'(shdnModeNv), 32'(modes[i]));
      check("enIdle", 32'(outputEnable), 32'hb);
      @(posedge ref_clk);
      extLevel[2] <= 1'b0;
      repeat (LATENCY_CYCLES) @(negedge ref_clk);
      check("enAct", 32'(outputEnable), modes[i] == SHDN_OFF ? 32'hb : 32'h0);
      @(posedge ref_clk);
      extLevel[2] <= 1'b1;
      repeat (20) @(negedge ref_clk);
      check("enRel", 32'(outputEnable), modes[i] == SHDN_LATCHING ? 32'h0 : 32'hb);
    end
    wr(SHDN_OFS, 32'h3);
    rdchk("shdnBad", SHDN_OFS, 32'(SHDN_OFF));
    $display("test shutdown done");
    wr(FUNC_LO_OFS, 32'h1516);
    rdchk("syncPin1", FUNC_LO_OFS, 32'h1511);
    wr(FUNC_LO_OFS, 32'h6511);
    rdchk("syncPin4", FUNC_LO_OFS, 32'h6511);
    wr(FUNC_HI_OFS, 32'h666);
    rdchk("syncHi", FUNC_HI_OFS, 32'h666);
    repeat (2) @(negedge ref_clk);
    check("syncDrive", 32'({pinOe_n[6:3], pinOut[6:3]}), 32'h0f);
    check("syncOut", 32'(syncOut), 32'h1);
    $display("test sync pins done");
    conclude();
  end
endmodule : digital_control_port_tb
